// File: pkg/adcdg_pkg.sv
// Purpose: Constants and types of the converter test-pattern and diagnostic register bank
// Assumes: Register indices are scaled by four to give Avalon byte addresses
// Notes:   All field positions and every reset value except the output-drive one live here
package adcdg_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] IDX_MODE        = 6'h20;
  localparam logic [5:0] IDX_OUTPUT_DRV  = 6'h22;
  localparam logic [5:0] IDX_PATTERN_0   = 6'h23;
  localparam logic [5:0] IDX_PATTERN_1   = 6'h24;
  localparam logic [5:0] IDX_PATTERN_2   = 6'h25;
  localparam logic [5:0] IDX_PATTERN_3   = 6'h26;
  localparam logic [5:0] IDX_DIAG_STATUS = 6'h34;
  localparam logic [5:0] IDX_ERR_STATUS  = 6'h35;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_DRIVE_DOUBLE = 0;
  localparam int BIT_POWERUP_DONE = 7;
  localparam int BIT_RESET_SEEN   = 6;
  localparam int BIT_CRC_ENABLE   = 0;
  localparam int BIT_CRC_ERROR    = 0;
  localparam int FMT_MSB          = 2;

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [2:0] FMT_TEST_PATTERN = 3'h4;
  localparam logic [2:0] RST_FORMAT       = 3'h0;
  localparam logic [7:0] RST_PATTERN_LOW  = 8'h0f;
  localparam logic [7:0] RST_PATTERN_HIGH = 8'h5a;
  localparam logic [7:0] RST_DIAG_STATUS  = 8'h40;
  localparam logic [7:0] RST_ERR_STATUS   = 8'h00;
  localparam int         PATTERN_BYTES    = 4;

  typedef enum logic [0:0] {
    ADCDG_BUS_IDLE,
    ADCDG_BUS_ACK
  } adcdg_bus_e;

endpackage

// File: logic/adcdg_regs.sv
// Purpose: Test-pattern and diagnostic register bank behind an Avalon-MM slave
// Assumes: Fuse checker, power-up monitor and converter data share sys_clk_in
// Notes:   Each access answers with waitrequest low exactly one cycle after it is taken
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module adcdg_regs
  import adcdg_pkg::*;
#(
  parameter int CONV_WIDTH = 32
)
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  input  wire logic        powerup_done_in,
  input  wire logic        reset_event_in,
  input  wire logic        fuse_crc_done_in,
  input  wire logic        fuse_crc_mismatch_in,
  input  wire logic [31:0] conv_ch0_in,
  input  wire logic [31:0] conv_ch1_in,
  output logic             waitrequest_out,
  output logic [31:0]      readdata_out,
  output logic             drive_strength_double_out,
  output logic [2:0]       output_format_select_out,
  output logic [31:0]      pattern_value_out,
  output logic             pattern_active_out,
  output logic             fuse_crc_start_out,
  output logic [31:0]      ch0_data_out,
  output logic [31:0]      ch1_data_out
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (CONV_WIDTH != 32)
  begin : g_width_check
    $error("adcdg_regs serves only a 32-bit channel word");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    adcdg_bus_e                      bus_state;
    logic                            waitreq;
    logic [31:0]                     rdata;
    logic                            is_write;
    logic                            be_low;
    logic [5:0]                      idx;
    logic [7:0]                      wdata;
    logic                            drive_dbl;
    logic [2:0]                      fmt;
    logic [PATTERN_BYTES-1:0][7:0]   pattern;
    logic                            pwr_done;
    logic                            rst_seen;
    logic                            crc_en;
    logic                            crc_start;
    logic                            crc_err;
    logic                            pat_active;
    logic [31:0]                     ch0;
    logic [31:0]                     ch1;
  } adcdg_state_s;

  adcdg_state_s state_reg;
  adcdg_state_s state_next;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Sticky flag: a set in the clearing cycle wins
  function automatic logic sticky_flag(input logic cur, input logic set, input logic clr);
    sticky_flag = set | (cur & ~clr);
  endfunction

  function automatic logic [7:0] read_mux(input adcdg_state_s s, input logic [5:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_MODE:
      begin
        v[FMT_MSB:0] = s.fmt;
      end
      IDX_OUTPUT_DRV:
      begin
        v[BIT_DRIVE_DOUBLE] = s.drive_dbl;
      end
      IDX_PATTERN_0:
      begin
        v = s.pattern[0];
      end
      IDX_PATTERN_1:
      begin
        v = s.pattern[1];
      end
      IDX_PATTERN_2:
      begin
        v = s.pattern[2];
      end
      IDX_PATTERN_3:
      begin
        v = s.pattern[3];
      end
      IDX_DIAG_STATUS:
      begin
        v[BIT_POWERUP_DONE] = s.pwr_done;
        v[BIT_RESET_SEEN]   = s.rst_seen;
        v[BIT_CRC_ENABLE]   = s.crc_en;
      end
      IDX_ERR_STATUS:
      begin
        v[BIT_CRC_ERROR] = s.crc_err;
      end
      default:
      begin
        v = 8'h00;
      end
    endcase
    read_mux = v;
  endfunction

  function automatic adcdg_state_s reset_state();
    adcdg_state_s r;
    r            = '0;
    r.bus_state  = ADCDG_BUS_IDLE;
    r.waitreq    = 1'b1;
    r.fmt        = RST_FORMAT;
    r.pattern[0] = RST_PATTERN_LOW;
    r.pattern[1] = RST_PATTERN_LOW;
    r.pattern[2] = RST_PATTERN_HIGH;
    r.pattern[3] = RST_PATTERN_HIGH;
    r.pwr_done   = RST_DIAG_STATUS[BIT_POWERUP_DONE];
    r.rst_seen   = RST_DIAG_STATUS[BIT_RESET_SEEN];
    r.crc_en     = RST_DIAG_STATUS[BIT_CRC_ENABLE];
    r.crc_err    = RST_ERR_STATUS[BIT_CRC_ERROR];
    reset_state  = r;
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic       wr_take;
    logic       rd_take;
    logic [7:0] wd;
    logic       clr_rst;
    logic       clr_err;
    logic       clr_pwr;
    logic       start_crc;
    wr_take   = 1'b0;
    rd_take   = 1'b0;
    wd        = state_reg.wdata;
    clr_rst   = 1'b0;
    clr_err   = 1'b0;
    clr_pwr   = 1'b0;
    start_crc = 1'b0;

    state_next = state_reg;

    case (state_reg.bus_state)
      ADCDG_BUS_IDLE:
      begin
        state_next.waitreq = 1'b1;
        if (read_in || write_in)
        begin
          state_next.bus_state = ADCDG_BUS_ACK;
          state_next.waitreq   = 1'b0;
          state_next.is_write  = write_in;
          state_next.be_low    = byteenable_in[0];
          state_next.idx       = address_in[7:2];
          state_next.wdata     = writedata_in[7:0];
          state_next.rdata     = write_in ? 32'h0000_0000
                                 : {24'h00_0000, read_mux(state_reg, address_in[7:2])};
        end
      end
      ADCDG_BUS_ACK:
      begin
        // Master sees waitrequest low at this edge; access takes effect here
        state_next.bus_state = ADCDG_BUS_IDLE;
        state_next.waitreq   = 1'b1;
        wr_take = state_reg.is_write & state_reg.be_low;
        rd_take = ~state_reg.is_write;
      end
      default:
      begin
        state_next.bus_state = ADCDG_BUS_IDLE;
        state_next.waitreq   = 1'b1;
      end
    endcase

    // ****************************************************************
    // Register writes
    // ****************************************************************
    if (wr_take)
    begin
      case (state_reg.idx)
        IDX_MODE:
        begin
          state_next.fmt = wd[FMT_MSB:0];
        end
        IDX_OUTPUT_DRV:
        begin
          state_next.drive_dbl = wd[BIT_DRIVE_DOUBLE];
        end
        IDX_PATTERN_0:
        begin
          state_next.pattern[0] = wd;
        end
        IDX_PATTERN_1:
        begin
          state_next.pattern[1] = wd;
        end
        IDX_PATTERN_2:
        begin
          state_next.pattern[2] = wd;
        end
        IDX_PATTERN_3:
        begin
          state_next.pattern[3] = wd;
        end
        IDX_DIAG_STATUS:
        begin
          clr_rst          = wd[BIT_RESET_SEEN];
          state_next.crc_en = wd[BIT_CRC_ENABLE];
          start_crc        = wd[BIT_CRC_ENABLE];
        end
        IDX_ERR_STATUS:
        begin
          clr_err = wd[BIT_CRC_ERROR];
        end
        default:
        begin
          clr_err = 1'b0;
        end
      endcase
    end

    // Power-up flag clears once software has read it
    if (rd_take && (state_reg.idx == IDX_DIAG_STATUS))
    begin
      clr_pwr = 1'b1;
    end

    // ****************************************************************
    // Flags
    // ****************************************************************
    state_next.pwr_done  = sticky_flag(state_reg.pwr_done, powerup_done_in, clr_pwr);
    state_next.rst_seen  = sticky_flag(state_reg.rst_seen, reset_event_in, clr_rst);
    state_next.crc_err   = sticky_flag(state_reg.crc_err,
                                       fuse_crc_done_in & fuse_crc_mismatch_in,
                                       clr_err);
    state_next.crc_start = start_crc;

    // ****************************************************************
    // Channel data
    // ****************************************************************
    state_next.pat_active = (state_reg.fmt == FMT_TEST_PATTERN);
    if (state_reg.fmt == FMT_TEST_PATTERN)
    begin
      state_next.ch0 = state_reg.pattern;
      state_next.ch1 = state_reg.pattern;
    end
    else
    begin
      state_next.ch0 = conv_ch0_in;
      state_next.ch1 = conv_ch1_in;
    end

    if (rst_in)
    begin
      state_next = reset_state();
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    state_reg <= state_next;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign waitrequest_out           = state_reg.waitreq;
  assign readdata_out              = state_reg.rdata;
  assign drive_strength_double_out = state_reg.drive_dbl;
  assign output_format_select_out  = state_reg.fmt;
  assign pattern_value_out         = state_reg.pattern;
  assign pattern_active_out        = state_reg.pat_active;
  assign fuse_crc_start_out        = state_reg.crc_start;
  assign ch0_data_out              = state_reg.ch0;
  assign ch1_data_out              = state_reg.ch1;

endmodule

`default_nettype wire

// File: verification/adcdg_fuse_model.sv
// Purpose: Fuse checker that answers start pulses
// Assumes: Same clock as the register bank
// Notes:   Mismatch toggles while no result is shown
`timescale 1ns/1ps
`default_nettype none
module adcdg_fuse_model #(
  parameter int LAT = 6
)
(
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic start_in,
  input  wire logic bad_in,
  output logic      done_out,
  output logic      mismatch_out
);
  int   cnt_reg;
  logic tog_reg;
  always_ff @(posedge sys_clk_in)
  begin
    tog_reg <= rst_in ? 1'b0 : !tog_reg;
    if (rst_in)
      cnt_reg <= 0;
    else if (start_in)
      cnt_reg <= LAT;
    else if (cnt_reg != 0)
      cnt_reg <= cnt_reg - 1;
  end
  assign done_out = (cnt_reg == 1);
  assign mismatch_out = done_out ? bad_in : tog_reg;
endmodule
`default_nettype wire

// File: verification/adcdg_regs_asserts.sv
// Purpose: Port checks for adcdg_regs
// Assumes: Bound into every adcdg_regs
// Notes:   Index is address bits 7:2
`timescale 1ns/1ps
`default_nettype none
module adcdg_asserts
  import adcdg_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  address_in,
  input wire logic        read_in,
  input wire logic        write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0]  byteenable_in,
  input wire logic [31:0] conv_ch0_in,
  input wire logic        waitrequest_out,
  input wire logic [31:0] readdata_out,
  input wire logic        drive_strength_double_out,
  input wire logic [2:0]  output_format_select_out,
  input wire logic [31:0] pattern_value_out,
  input wire logic        pattern_active_out,
  input wire logic        fuse_crc_start_out,
  input wire logic [31:0] ch0_data_out
);
  logic       wr_ok;
  logic [5:0] idx;
  logic [2:0] wd;
  logic       sel;
  assign wr_ok = write_in && !waitrequest_out && byteenable_in[0];
  assign idx = address_in[7:2];
  assign wd = writedata_in[2:0];
  assign sel = output_format_select_out == FMT_TEST_PATTERN;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  chk_wait_one: assert property ((read_in || write_in) && waitrequest_out |=>
    !waitrequest_out ##1 waitrequest_out) else $error("Wait not one cycle");
  chk_read_zero: assert property (!waitrequest_out |-> readdata_out[31:8] == 24'h0)
    else $error("Upper read bits set");
  chk_fmt_write: assert property (
    wr_ok && idx == IDX_MODE |=> output_format_select_out == $past(wd)) else $error("Bad format");
  chk_drive_cause: assert property (!$past(rst_in) && !$stable(drive_strength_double_out) |->
    $past(wr_ok) && $past(idx) == IDX_OUTPUT_DRV) else $error("Drive changed alone");
  chk_crc_pulse: assert property (wr_ok && idx == IDX_DIAG_STATUS && wd[0] |=>
    fuse_crc_start_out ##1 !fuse_crc_start_out) else $error("Start pulse wrong");
  chk_crc_cause: assert property (!$past(rst_in) && fuse_crc_start_out |->
    $past(wr_ok) && $past(idx) == IDX_DIAG_STATUS) else $error("Start without write");
  chk_ch0_path: assert property (!$past(rst_in) |-> ch0_data_out ==
    ($past(sel) ? $past(pattern_value_out) : $past(conv_ch0_in))) else $error("Ch0 wrong");
  chk_pat_active: assert property (!$past(rst_in) |-> pattern_active_out == $past(sel))
    else $error("Active flag wrong");
endmodule
bind adcdg_regs adcdg_asserts chk_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .address_in(address_in), .read_in(read_in), .write_in(write_in),
  .writedata_in(writedata_in), .byteenable_in(byteenable_in), .conv_ch0_in(conv_ch0_in),
  .waitrequest_out(waitrequest_out), .readdata_out(readdata_out),
  .drive_strength_double_out(drive_strength_double_out),
  .output_format_select_out(output_format_select_out),
  .pattern_value_out(pattern_value_out), .pattern_active_out(pattern_active_out),
  .fuse_crc_start_out(fuse_crc_start_out), .ch0_data_out(ch0_data_out));
`default_nettype wire

// File: verification/test_adc_diag_test_pattern_regs.sv
// Purpose: Self-checking bench for adcdg_regs
// Assumes: Fuse checker is adcdg_fuse_model
// Notes:   Bus waits are bounded
`timescale 1ns/1ps
`default_nettype none
module test_adc_diag_test_pattern_regs;
  logic        sys_clk_in, rst_in, read_in, write_in, powerup_done_in, reset_event_in;
  logic        bad, done, mism, start, wq, drive, active;
  logic [7:0]  address_in;
  logic [3:0]  byteenable_in;
  logic [2:0]  fmt;
  logic [31:0] writedata_in, conv0, conv1, rdata, pat, ch0, ch1, rdq;
  int          fail_count;
  int          tests_run;
  adcdg_regs #(.CONV_WIDTH(32)) dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .powerup_done_in(powerup_done_in), .reset_event_in(reset_event_in),
    .fuse_crc_done_in(done), .fuse_crc_mismatch_in(mism), .conv_ch0_in(conv0),
    .conv_ch1_in(conv1), .waitrequest_out(wq), .readdata_out(rdata),
    .drive_strength_double_out(drive), .output_format_select_out(fmt),
    .pattern_value_out(pat), .pattern_active_out(active), .fuse_crc_start_out(start),
    .ch0_data_out(ch0), .ch1_data_out(ch1));
  adcdg_fuse_model #(.LAT(6)) fuse_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .start_in(start), .bad_in(bad), .done_out(done), .mismatch_out(mism));
  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    conv0 <= conv0 + 32'h3;
    conv1 <= conv1 - 32'h5;
  end
  task automatic tally_and_finish;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic be);
    int n;
    @(posedge sys_clk_in);
    address_in <= a;
    writedata_in <= {24'h0, d};
    byteenable_in <= {3'h0, be};
    write_in <= w;
    read_in <= !w;
    n = 0;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (wq !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      fail_count++;
      $display("[FAIL] %0t bus timeout", $time);
      tally_and_finish();
    end
    rdq = rdata;
    write_in <= 1'b0;
    read_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 1'b1);
    chk(rdq, {24'h0, e});
  endtask
  task automatic do_reset;
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n >= 50)
    begin
      fail_count++;
      $display("[FAIL] %0t fuse timeout", $time);
      tally_and_finish();
    end
  endtask
  task automatic t_reset;
    chk(pat, 32'h5a5a0f0f);
    rd(8'h8c, 8'h0f);
    rd(8'h90, 8'h0f);
    rd(8'h94, 8'h5a);
    rd(8'h98, 8'h5a);
    rd(8'hd0, 8'h40);
    rd(8'hd4, 8'h00);
    rd(8'h88, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_pattern;
    wr(8'h8c, 8'h11);
    wr(8'h90, 8'h22);
    wr(8'h94, 8'h33);
    wr(8'h98, 8'h44);
    bus(1'b1, 8'h98, 8'hff, 1'b0);
    rd(8'h98, 8'h44);
    chk(pat, 32'h44332211);
    $display("pattern test done");
  endtask
  task automatic t_format;
    for (int f = 0; f < 5; f++)
    begin
      wr(8'h80, 8'(f));
      rd(8'h80, 8'(f));
      chk({29'h0, fmt}, 32'(f));
      chk(ch0, f == 4 ? 32'h44332211 : conv0 - 32'h3);
      chk(ch1, f == 4 ? 32'h44332211 : conv1 + 32'h5);
      chk({31'h0, active}, {31'h0, f == 4});
    end
    wr(8'h80, 8'hff);
    rd(8'h80, 8'h07);
    wr(8'h80, 8'h00);
    $display("format test done");
  endtask
  task automatic t_drive;
    wr(8'h88, 8'hff);
    rd(8'h88, 8'h01);
    chk({31'h0, drive}, 32'h1);
    wr(8'h88, 8'h00);
    wr(8'h00, 8'h55);
    rd(8'h00, 8'h00);
    chk({31'h0, drive}, 32'h0);
    $display("drive test done");
  endtask
  task automatic t_diag;
    @(posedge sys_clk_in);
    powerup_done_in <= 1'b1;
    @(posedge sys_clk_in);
    powerup_done_in <= 1'b0;
    rd(8'hd0, 8'hc0);
    rd(8'hd0, 8'h40);
    wr(8'hd0, 8'h80);
    rd(8'hd0, 8'h40);
    wr(8'hd0, 8'h40);
    rd(8'hd0, 8'h00);
    @(posedge sys_clk_in);
    reset_event_in <= 1'b1;
    @(posedge sys_clk_in);
    reset_event_in <= 1'b0;
    rd(8'hd0, 8'h40);
    $display("diag test done");
  endtask
  task automatic t_crc;
    bad <= 1'b1;
    wr(8'hd0, 8'h01);
    wait_done();
    rd(8'hd4, 8'h01);
    rd(8'hd0, 8'h41);
    wr(8'hd4, 8'h00);
    rd(8'hd4, 8'h01);
    wr(8'hd4, 8'h01);
    rd(8'hd4, 8'h00);
    bad <= 1'b0;
    wr(8'hd0, 8'h01);
    wait_done();
    rd(8'hd4, 8'h00);
    $display("crc test done");
  endtask
  initial
  begin
    fail_count = 0;
    tests_run = 0;
    rst_in = 1'b1;
    read_in = 1'b0;
    write_in = 1'b0;
    address_in = 8'h00;
    writedata_in = 32'h0;
    byteenable_in = 4'h1;
    powerup_done_in = 1'b0;
    reset_event_in = 1'b0;
    bad = 1'b0;
    conv0 = 32'h0;
    conv1 = 32'hffffffff;
    do_reset();
    t_reset();
    t_pattern();
    t_format();
    t_drive();
    t_diag();
    t_crc();
    do_reset();
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
